// file: pkg/edt_pkg.sv
// Constants and carriers shared by the edge-thinning filter.
// Assumes a 32-bit APB master and a single 20 MHz clock.
package edt_pkg;

  // ------------------------------------------------------------
  // Bus and counter widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 12'h008;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTRL_OUT_EN = 0;
  localparam int CTRL_LED_ON = 1;
  localparam int CTRL_REINIT = 2;
  localparam int STAT_PARITY = 0;
  localparam int STAT_SAMPLE = 1;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic             RST_OUT_EN = 1'b0;
  localparam logic             RST_LED_ON = 1'b0;
  localparam logic             RST_PARITY = 1'b0;
  localparam logic [CNT_W-1:0] RST_COUNT  = 16'h0000;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } edt_apb_req_t;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } edt_apb_rsp_t;

  // Answer phase of the bus slave
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } edt_bus_st_t;

endpackage

// file: logic/edt_rise_det.sv
// Rising-edge detector cell: one-cycle pulse per low-to-high change.
// Assumes the level is synchronous to clock.
`timescale 1ns/10ps
module edt_rise_det (
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // Level in, pulse out
  input  wire logic level,
  output logic      rise
);

  logic prev_q;
  logic prev_d;
  logic rise_q;
  logic rise_d;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    prev_d = level;
    rise_d = level & ~prev_q;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prev_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      rise_q <= rise_d;
    end
  end

  assign rise = rise_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_rise_single: assert property (@(posedge clock) disable iff (!nrst)
    rise_q |=> !rise_q)
    else $error("rise pulse longer than one cycle");

endmodule

// file: logic/edt_thin_filter.sv
// Edge-thinning event filter with APB register access.
// Assumes synchronous pins, one 20 MHz clock, APB master waiting for pready.
//
// Contract
// - Pass one of every two input edges
// - Mask first rising edge, pass second, repeat
// - Thinning clock sets the edge sampling interval
// - Second edge emits one output pulse
// - Masked edge raises no interrupt
// - Passed edge raises interrupt to wake processor
// - Output disabled means no interrupt at all
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/10ps
module edt_thin_filter
  import edt_pkg::*;
(
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          nrst,
  // Register bus
  input  wire edt_apb_req_t  apb_req,
  output edt_apb_rsp_t       apb_rsp,
  // Pins
  input  wire logic          input_port_pin,
  input  wire logic          thin_clock,
  output logic               led_port_pin,
  // Event out
  output logic               thinned_event_interrupt
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  edt_bus_st_t       bus_q;
  edt_bus_st_t       bus_d;
  edt_apb_rsp_t      rsp_q;
  edt_apb_rsp_t      rsp_d;
  logic              out_en_q;
  logic              out_en_d;
  logic              led_on_q;
  logic              led_on_d;
  logic              led_pin_q;
  logic              led_pin_d;
  logic              parity_q;
  logic              parity_d;
  logic              sample_q;
  logic              sample_d;
  logic              irq_q;
  logic              irq_d;
  logic [CNT_W-1:0]  count_q;
  logic [CNT_W-1:0]  count_d;
  logic              thin_tick;
  logic              edge_seen;
  logic              access;
  logic              wr_take;
  logic              wr_ctrl;
  logic              reinit;
  logic              hit;
  logic [DATA_W-1:0] rd_val;

  // ------------------------------------------------------------
  // Thinning clock edge detection
  // ------------------------------------------------------------
  edt_rise_det u_thin_det (
    .clock (clock),
    .nrst  (nrst),
    .level (thin_clock),
    .rise  (thin_tick)
  );

  // Input pin is looked at only on a thinning clock tick
  assign edge_seen = thin_tick & input_port_pin & ~sample_q;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  assign access  = apb_req.psel & apb_req.penable;
  assign wr_take = access & apb_req.pwrite & rsp_q.pready;
  assign wr_ctrl = wr_take & (apb_req.paddr == OFS_CTRL);
  assign reinit  = wr_ctrl & apb_req.pwdata[CTRL_REINIT];

  always_comb begin
    hit    = 1'b1;
    rd_val = '0;
    unique case (apb_req.paddr)
      OFS_CTRL: begin
        rd_val[CTRL_OUT_EN] = out_en_q;
        rd_val[CTRL_LED_ON] = led_on_q;
      end
      OFS_STATUS: begin
        rd_val[STAT_PARITY] = parity_q;
        rd_val[STAT_SAMPLE] = sample_q;
      end
      OFS_COUNT: begin
        rd_val[CNT_W-1:0] = count_q;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Bus answer: one wait state, ready for one cycle
  // ------------------------------------------------------------
  always_comb begin
    bus_d = bus_q;
    rsp_d = rsp_q;
    unique case (bus_q)
      BUS_IDLE: begin
        rsp_d = '0;
        if (access) begin
          bus_d          = BUS_DONE;
          rsp_d.pready   = 1'b1;
          rsp_d.pslverr  = ~hit;
          rsp_d.prdata   = apb_req.pwrite ? '0 : rd_val;
        end
      end
      BUS_DONE: begin
        bus_d = BUS_IDLE;
        rsp_d = '0;
      end
      default: begin
        bus_d = BUS_IDLE;
        rsp_d = '0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bus_q <= BUS_IDLE;
      rsp_q <= '0;
    end else begin
      bus_q <= bus_d;
      rsp_q <= rsp_d;
    end
  end

  assign apb_rsp = rsp_q;

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  always_comb begin
    out_en_d  = out_en_q;
    led_on_d  = led_on_q;
    if (wr_ctrl) begin
      out_en_d = apb_req.pwdata[CTRL_OUT_EN];
      led_on_d = apb_req.pwdata[CTRL_LED_ON];
    end
    led_pin_d = ~led_on_d;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      out_en_q  <= RST_OUT_EN;
      led_on_q  <= RST_LED_ON;
      led_pin_q <= ~RST_LED_ON;
    end else begin
      out_en_q  <= out_en_d;
      led_on_q  <= led_on_d;
      led_pin_q <= led_pin_d;
    end
  end

  assign led_port_pin = led_pin_q;

  // ------------------------------------------------------------
  // Thinning core
  // ------------------------------------------------------------
  always_comb begin
    sample_d = thin_tick ? input_port_pin : sample_q;
    parity_d = parity_q;
    irq_d    = 1'b0;
    count_d  = count_q;
    if (reinit) begin
      parity_d = RST_PARITY;
      count_d  = RST_COUNT;
    end else if (edge_seen) begin
      parity_d = ~parity_q;
      if (parity_q) begin
        irq_d   = out_en_q;
        count_d = count_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sample_q <= 1'b0;
      parity_q <= RST_PARITY;
      irq_q    <= 1'b0;
      count_q  <= RST_COUNT;
    end else begin
      sample_q <= sample_d;
      parity_q <= parity_d;
      irq_q    <= irq_d;
      count_q  <= count_d;
    end
  end

  assign thinned_event_interrupt = irq_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_half_rate: assert property (@(posedge clock) disable iff (!nrst)
    irq_q |-> ($past(parity_q) && !parity_q))
    else $error("pulse not on second edge of a pair");

  a_first_masked: assert property (@(posedge clock) disable iff (!nrst)
    (edge_seen && !parity_q && !reinit) |=> (parity_q && !irq_q))
    else $error("first edge not masked");

  a_tick_gates: assert property (@(posedge clock) disable iff (!nrst)
    (!thin_tick && !reinit) |=> ($stable(sample_q) && $stable(parity_q)))
    else $error("filter state moved without thinning tick");

  a_pulse_once: assert property (@(posedge clock) disable iff (!nrst)
    (edge_seen && parity_q && out_en_q && !reinit) |=> irq_q ##1 !irq_q)
    else $error("second edge did not give one pulse");

  a_masked_quiet: assert property (@(posedge clock) disable iff (!nrst)
    (edge_seen && !parity_q) |=> !irq_q)
    else $error("interrupt on masked edge");

  a_wake_cause: assert property (@(posedge clock) disable iff (!nrst)
    irq_q |-> $past(edge_seen && out_en_q))
    else $error("interrupt without enabled edge");

  a_disabled_quiet: assert property (@(posedge clock) disable iff (!nrst)
    !out_en_q |=> !irq_q)
    else $error("interrupt while output disabled");

  a_reinit_clear: assert property (@(posedge clock) disable iff (!nrst)
    reinit |=> (!parity_q && count_q == RST_COUNT))
    else $error("reinit did not clear parity");

  a_ready_single: assert property (@(posedge clock) disable iff (!nrst)
    rsp_q.pready |=> !rsp_q.pready)
    else $error("pready longer than one cycle");

endmodule

// file: verification/edt_src_model.sv
// Partner model: pulse source, thinning clock, halting processor.
// Assumes the bench strobes go and sleep for one cycle each.
`timescale 1ns/10ps
module edt_src_model (
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // Commands
  input  wire logic go,
  input  wire logic sleep,
  input  wire logic tick_en,
  // Pins and event
  input  wire logic irq,
  output logic      pin,
  output logic      tclk,
  output logic      halted
);
  // ----------
  // Source and halt state
  // ----------
  logic [1:0] div_q;
  logic [5:0] len_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_q  <= 2'h0;
      len_q  <= 6'h00;
      halted <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      len_q <= go ? 6'h3F : (len_q != 6'h00 ? len_q - 6'h01 : len_q);
      if (sleep) begin
        halted <= 1'b1;
      end else if (irq) begin
        halted <= 1'b0;
      end
    end
  end
  assign pin  = len_q > 6'h1F;
  assign tclk = div_q[1] & tick_en;
endmodule

// file: verification/tb.sv
// Testbench: APB master, pulse partner, self-checking scenarios.
// Assumes one 20 MHz clock and the partner beside the filter.
`timescale 1ns/10ps
module tb import edt_pkg::*;;
  // ----------
  // Signals
  // ----------
  logic              clock;
  logic              nrst;
  edt_apb_req_t      req;
  edt_apb_rsp_t      rsp;
  logic              go, sleep, tick_en;
  logic              pin, tclk, led, irq, halted;
  logic [DATA_W-1:0] d;
  logic              e;
  int                errors, comparisons, irq_cnt;

  edt_thin_filter u_dut (.clock(clock), .nrst(nrst), .apb_req(req), .apb_rsp(rsp),
    .input_port_pin(pin), .thin_clock(tclk), .led_port_pin(led), .thinned_event_interrupt(irq));
  edt_src_model u_src (.clock(clock), .nrst(nrst), .go(go), .sleep(sleep), .tick_en(tick_en),
    .irq(irq), .pin(pin), .tclk(tclk), .halted(halted));

  initial clock = 1'b0;
  always #25 clock = ~clock;
  always @(posedge clock) if (irq === 1'b1) irq_cnt++;

  // ----------
  // Helpers
  // ----------
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t %s: seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    req <= '{1'b1, 1'b0, w, a, wd};
    @(posedge clock);
    req.penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    d = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    if (rsp.pready !== 1'b1) begin
      errors++;
      $display("[ERR] %0t bus timeout", $time);
      tally_and_finish();
    end
  endtask

  task automatic pulse();
    @(posedge clock);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (66) @(posedge clock);
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic test_reset();
    chk(led, 32'h1, "led off");
    chk(irq, 32'h0, "no event at reset");
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(d[0], 32'h0, "parity at reset");
    apb(1'b0, 12'h00C, 32'h0);
    chk(e, 32'h1, "unmapped error");
    $display("test_reset done");
  endtask

  task automatic test_thin();
    apb(1'b1, OFS_CTRL, 32'h3);
    @(posedge clock);
    chk(led, 32'h0, "led on");
    @(posedge clock);
    sleep <= 1'b1;
    @(posedge clock);
    sleep <= 1'b0;
    irq_cnt = 0;
    pulse();
    chk(irq_cnt, 32'h0, "first edge masked");
    chk(halted, 32'h1, "still halted");
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(d[0], 32'h1, "parity set");
    pulse();
    chk(irq_cnt, 32'h1, "one pulse");
    chk(halted, 32'h0, "woken");
    apb(1'b0, OFS_COUNT, 32'h0);
    chk(d, 32'h1, "count one");
    $display("test_thin done");
  endtask

  task automatic test_off();
    apb(1'b1, OFS_CTRL, 32'h0);
    @(posedge clock);
    chk(led, 32'h1, "led off");
    irq_cnt = 0;
    repeat (3) pulse();
    chk(irq_cnt, 32'h0, "no event when off");
    apb(1'b0, OFS_COUNT, 32'h0);
    chk(d, 32'h2, "count two");
    tick_en <= 1'b0;
    pulse();
    tick_en <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(d[0], 32'h1, "no tick no edge");
    $display("test_off done");
  endtask

  task automatic test_reinit();
    apb(1'b1, OFS_CTRL, 32'h7);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(d[0], 32'h0, "parity cleared");
    apb(1'b0, OFS_COUNT, 32'h0);
    chk(d, 32'h0, "count cleared");
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(d, 32'h3, "reinit reads zero");
    irq_cnt = 0;
    pulse();
    chk(irq_cnt, 32'h0, "masked again");
    pulse();
    chk(irq_cnt, 32'h1, "second passes");
    $display("test_reinit done");
  endtask

  initial begin
    errors = 0;
    comparisons = 0;
    irq_cnt = 0;
    req = '0;
    go = 1'b0;
    sleep = 1'b0;
    tick_en = 1'b1;
    nrst = 1'b0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    test_reset();
    test_thin();
    test_off();
    test_reinit();
    tally_and_finish();
  end
endmodule
